// [design/tws_pkg.sv]
// constants, register map and bus carrier for the transmit word scheduler
package tws_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int TWS_SLOTS = 10;
	localparam int TWS_CLK_MHZ = 50;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] TWS_A_CTRL = 12'h000;
	localparam logic [11:0] TWS_A_EQUIPMENT_IDENTIFIER = 12'h004;
	localparam logic [11:0] TWS_A_DECODE = 12'h008;
	localparam logic [11:0] TWS_A_STATUS = 12'h00C;
	localparam logic [11:0] TWS_A_SLOT_BASE = 12'h040;
	localparam int TWS_SLOT_SHIFT = 5;
	localparam logic [4:0] TWS_O_WORD = 5'h00;
	localparam logic [4:0] TWS_O_IVAL = 5'h04;
	localparam logic [4:0] TWS_O_STEP = 5'h08;
	localparam logic [4:0] TWS_O_MAX = 5'h0C;
	localparam logic [4:0] TWS_O_MIN = 5'h10;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TWS_CTRL_HS = 0;
	localparam int TWS_CTRL_ODD = 1;
	localparam int TWS_CTRL_RETAIN = 2;
	localparam int TWS_IVAL_EN = 31;
	localparam int TWS_STEP_BOUNCE = 16;
	localparam int TWS_RAMP_LSB = 16;
	localparam int TWS_RAMP_MSB = 27;
	localparam int TWS_SDI_LSB = 8;
	localparam int TWS_SDI_MSB = 9;
	localparam int TWS_SSM_LSB = 29;
	localparam int TWS_SSM_MSB = 30;
	localparam int TWS_PARITY = 31;
	// ----------------------------------------
	// reset values and limits
	// ----------------------------------------
	localparam logic [2:0] TWS_RST_CTRL = 3'h0;
	localparam logic [7:0] TWS_RST_EQUIPMENT_IDENTIFIER = 8'h00;
	localparam logic [7:0] TWS_DEF_DECODE = 8'h00;
	localparam logic [15:0] TWS_IVAL_MIN_MS = 16'h0004;
	localparam logic [15:0] TWS_IVAL_MAX_MS = 16'hEA5E;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int TWS_BIT_HS_NS = 10000;
	localparam int TWS_BIT_LS_NS = 80000;
	localparam int TWS_MS_NS = 1000000;
	localparam int TWS_GAP_BITS = 4;
	localparam int TWS_CYC_BIT_HS = TWS_BIT_HS_NS * TWS_CLK_MHZ / 1000;
	localparam int TWS_CYC_BIT_LS = TWS_BIT_LS_NS * TWS_CLK_MHZ / 1000;
	localparam int TWS_CYC_GAP = TWS_GAP_BITS * TWS_CYC_BIT_LS;
	localparam int TWS_CYC_MS = TWS_MS_NS / 1000 * TWS_CLK_MHZ;
	// ----------------------------------------
	// bus carrier
	// ----------------------------------------
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} tws_bus_t;
endpackage

// [design/tws_serial.sv]
// bipolar return-to-zero word serialiser with trailing inter-word gap
`timescale 1ns/1ns
`default_nettype none
module tws_serial #(
	parameter int GAP_CYC = tws_pkg::TWS_CYC_GAP
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic START_I,
	input wire logic [31:0] WORD_I,
	input wire logic HS_I,
	output logic READY_O,
	output logic HI_O,
	output logic LO_O
);
	import tws_pkg::*;
	typedef enum logic [1:0] {S_IDLE, S_BIT, S_GAP} tws_ser_t;
	tws_ser_t st_reg, st_next;
	logic [31:0] sh_reg, sh_next;
	logic [4:0] bit_reg, bit_next;
	logic [15:0] cnt_reg, cnt_next;
	logic hs_reg, hs_next, hi_reg, hi_next, lo_reg, lo_next;
	logic [15:0] per;

	always_comb begin
		per = hs_reg ? 16'(TWS_CYC_BIT_HS) : 16'(TWS_CYC_BIT_LS);
		st_next = st_reg;
		sh_next = sh_reg;
		bit_next = bit_reg;
		cnt_next = cnt_reg + 16'h0001;
		hs_next = hs_reg;
		hi_next = 1'b0;
		lo_next = 1'b0;
		case (st_reg)
			S_IDLE: begin
				cnt_next = 16'h0000;
				if (START_I) begin
					st_next = S_BIT;
					sh_next = WORD_I;
					hs_next = HS_I;
					bit_next = 5'h00;
				end
			end
			S_BIT: begin
				hi_next = (cnt_reg < per / 2) && sh_reg[0];
				lo_next = (cnt_reg < per / 2) && !sh_reg[0];
				if (cnt_reg == per - 16'h0001) begin
					cnt_next = 16'h0000;
					sh_next = {1'b0, sh_reg[31:1]};
					bit_next = bit_reg + 5'h01;
					hi_next = 1'b0;
					lo_next = 1'b0;
					if (bit_reg == 5'h1F) begin
						st_next = S_GAP;
					end
				end
			end
			S_GAP: begin
				if (cnt_reg == 16'(GAP_CYC - 1)) begin
					st_next = S_IDLE;
				end
			end
			default: st_next = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_reg <= S_IDLE;
			sh_reg <= 32'h0000_0000;
			bit_reg <= 5'h00;
			cnt_reg <= 16'h0000;
			hs_reg <= 1'b0;
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			sh_reg <= sh_next;
			bit_reg <= bit_next;
			cnt_reg <= cnt_next;
			hs_reg <= hs_next;
			hi_reg <= hi_next;
			lo_reg <= lo_next;
		end
	end

	assign READY_O = (st_reg == S_IDLE);
	assign HI_O = hi_reg;
	assign LO_O = lo_reg;

	AST_GAP_LEN: assert property (@(posedge CLK_I) disable iff (RST_I)
		(st_reg == S_GAP && cnt_reg == 16'h0000) |-> (st_reg == S_GAP) [*8])
		else $error("gap ended early");
	AST_RZ_EXCL: assert property (@(posedge CLK_I) disable iff (RST_I)
		!(hi_reg && lo_reg) && !(READY_O && (hi_reg || lo_reg)))
		else $error("line driven both ways or outside a word");
endmodule
`default_nettype wire

// [design/tws_top.sv]
// ten-slot transmit word scheduler with ramping data and retention
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - ten slots, each sent as a 32-bit bipolar RZ word
// - every slot has its own repetition interval
// - interval 4 to 59998 ms; zero selects the default rate
// - at least four low-speed bit times between any two words
// - retention on: slots survive power-off and transmission resumes
// - retention off: all slots cleared when power returns
// - retention flag survives power cycles, changed only by software
// - signed step per slot; zero step disables ramping
// - signed upper and lower limit bound the ramped data
// - only word bits 28..17 of a limit are kept and compared
// - bounce mode ramps to a limit, reverses, repeats forever
// - wrap mode ramps to the limit then reloads the opposite limit
// - identifier in bits 10..9, sign/status in bits 31..30
// - valid equipment identifier selects decoding, else default
// - equipment identifier kept until replaced, or until power returns with retention off
// - transmit rate 100 or 12.5 kbps, own selection
// - parity bit odd or even by one selection
module tws_top #(
	parameter int CYC_PER_MS = tws_pkg::TWS_CYC_MS,
	parameter int GAP_CYC = tws_pkg::TWS_CYC_GAP,
	parameter logic [15:0] DEFAULT_IVAL_MS = 16'h0064,
	parameter logic [255:0] EQUIPMENT_IDENTIFIER_VALID = {255'h0, 1'b0} | ~256'h1
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire tws_pkg::tws_bus_t BUS_I,
	output logic [31:0] RDATA_O,
	input wire logic PWR_GOOD_I,
	output logic TX_HI_O,
	output logic TX_LO_O
);
	import tws_pkg::*;
	localparam int N = TWS_SLOTS;
	localparam int MSW = $clog2(CYC_PER_MS + 1);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] word_reg [N], word_next [N];
	logic [15:0] ival_reg [N], ival_next [N];
	logic [15:0] cnt_reg [N], cnt_next [N];
	logic [11:0] step_reg [N], step_next [N];
	logic [11:0] max_reg [N], max_next [N];
	logic [11:0] min_reg [N], min_next [N];
	logic [N-1:0] en_reg, en_next, due_reg, due_next;
	logic [N-1:0] bnc_reg, bnc_next, dir_reg, dir_next;
	logic [MSW-1:0] ms_reg, ms_next;
	logic hs_reg, hs_next, odd_reg, odd_next, ret_reg, ret_next;
	logic [7:0] equipment_identifier_reg, equipment_identifier_next;
	logic [31:0] rd_reg, rd_next;
	logic pg1_reg, pg2_reg, pg3_reg;
	logic tick, start, ser_ready, pwr_rise, in_slot;
	logic [3:0] pick, sidx;
	logic [4:0] soff;
	logic [11:0] rel;
	logic [31:0] tx_word;
	logic [12:0] ramp;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// interval range and default
	function automatic logic [15:0] clamp_ival(input logic [15:0] v);
		if (v == 16'h0000) begin
			return 16'h0000;
		end else if (v < TWS_IVAL_MIN_MS) begin
			return TWS_IVAL_MIN_MS;
		end else if (v > TWS_IVAL_MAX_MS) begin
			return TWS_IVAL_MAX_MS;
		end
		return v;
	endfunction

	function automatic logic [15:0] eff_ival(input logic [15:0] v);
		return (v == 16'h0000) ? DEFAULT_IVAL_MS : v;
	endfunction

	// returns {direction up, new value}; 13-bit math avoids overflow at the limits
	function automatic logic [12:0] ramp_f(input logic [11:0] v, input logic [11:0] st, input logic [11:0] mx,
			input logic [11:0] mn, input logic bnc, input logic dir);
		logic signed [12:0] sv, mag, smx, smn, nv;
		logic up;
		sv = 13'(signed'(v));
		smx = 13'(signed'(mx));
		smn = 13'(signed'(mn));
		mag = st[11] ? -13'(signed'(st)) : 13'(signed'(st));
		up = bnc ? dir : !st[11];
		nv = up ? sv + mag : sv - mag;
		if (bnc) begin
			if (up && nv >= smx) begin
				return {1'b0, smx[11:0]};
			end else if (!up && nv <= smn) begin
				return {1'b1, smn[11:0]};
			end
			return {up, nv[11:0]};
		end
		if (up) begin
			if (sv >= smx) begin
				return {dir, smn[11:0]};
			end
			return {dir, (nv > smx) ? smx[11:0] : nv[11:0]};
		end
		if (sv <= smn) begin
			return {dir, smx[11:0]};
		end
		return {dir, (nv < smn) ? smn[11:0] : nv[11:0]};
	endfunction

	// ----------------------------------------
	// power sense and decode
	// ----------------------------------------
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pg1_reg <= 1'b0;
			pg2_reg <= 1'b0;
			pg3_reg <= 1'b0;
		end else begin
			pg1_reg <= PWR_GOOD_I;
			pg2_reg <= pg1_reg;
			pg3_reg <= pg2_reg;
		end
	end
	assign pwr_rise = pg2_reg && !pg3_reg;

	always_comb begin
		rel = BUS_I.addr - TWS_A_SLOT_BASE;
		sidx = 4'(rel >> TWS_SLOT_SHIFT);
		soff = rel[4:0];
		in_slot = (BUS_I.addr >= TWS_A_SLOT_BASE) && ((rel >> TWS_SLOT_SHIFT) < 12'(N));
		pick = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (due_reg[i]) begin
				pick = 4'(i);
			end
		end
		// halt while power is down so nothing leaves half-sent
		start = pg2_reg && ser_ready && (|due_reg);
		ramp = ramp_f(word_reg[pick][TWS_RAMP_MSB:TWS_RAMP_LSB], step_reg[pick], max_reg[pick], min_reg[pick],
			bnc_reg[pick], dir_reg[pick]);
		tx_word = {(^word_reg[pick][30:0]) ^ odd_reg, word_reg[pick][30:0]};
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		word_next = word_reg;
		ival_next = ival_reg;
		cnt_next = cnt_reg;
		step_next = step_reg;
		max_next = max_reg;
		min_next = min_reg;
		en_next = en_reg;
		due_next = due_reg;
		bnc_next = bnc_reg;
		dir_next = dir_reg;
		hs_next = hs_reg;
		odd_next = odd_reg;
		ret_next = ret_reg;
		equipment_identifier_next = equipment_identifier_reg;
		rd_next = 32'h0000_0000;
		tick = (ms_reg == MSW'(CYC_PER_MS - 1));
		ms_next = tick ? '0 : ms_reg + MSW'(1);
		if (start) begin
			due_next[pick] = 1'b0;
			if (step_reg[pick] != 12'h000) begin
				word_next[pick][TWS_RAMP_MSB:TWS_RAMP_LSB] = ramp[11:0];
				dir_next[pick] = ramp[12];
			end
		end
		// independent countdowns; a new due wins over the clear above
		for (int i = 0; i < N; i++) begin
			if (en_reg[i] && tick && pg2_reg) begin
				if (cnt_reg[i] <= 16'h0001) begin
					due_next[i] = 1'b1;
					cnt_next[i] = eff_ival(ival_reg[i]);
				end else begin
					cnt_next[i] = cnt_reg[i] - 16'h0001;
				end
			end
		end
		if (BUS_I.wr) begin
			if (BUS_I.addr == TWS_A_CTRL) begin
				hs_next = BUS_I.wdata[TWS_CTRL_HS];
				odd_next = BUS_I.wdata[TWS_CTRL_ODD];
				ret_next = BUS_I.wdata[TWS_CTRL_RETAIN];
			end else if (BUS_I.addr == TWS_A_EQUIPMENT_IDENTIFIER) begin
				equipment_identifier_next = BUS_I.wdata[7:0];
			end else if (in_slot) begin
				case (soff)
					// sdi and ssm stored in place
					TWS_O_WORD: word_next[sidx] = BUS_I.wdata;
					TWS_O_IVAL: begin
						ival_next[sidx] = clamp_ival(BUS_I.wdata[15:0]);
						en_next[sidx] = BUS_I.wdata[TWS_IVAL_EN];
						cnt_next[sidx] = 16'h0000;
					end
					TWS_O_STEP: begin
						step_next[sidx] = BUS_I.wdata[11:0];
						bnc_next[sidx] = BUS_I.wdata[TWS_STEP_BOUNCE];
						dir_next[sidx] = !BUS_I.wdata[11];
					end
					TWS_O_MAX: max_next[sidx] = BUS_I.wdata[TWS_RAMP_MSB:TWS_RAMP_LSB];
					TWS_O_MIN: min_next[sidx] = BUS_I.wdata[TWS_RAMP_MSB:TWS_RAMP_LSB];
					default: ;
				endcase
			end
		end
		// identifier cleared when power returns unless retained
		if (pwr_rise && !ret_reg) begin
			for (int i = 0; i < N; i++) begin
				word_next[i] = 32'h0000_0000;
				ival_next[i] = 16'h0000;
				cnt_next[i] = 16'h0000;
				step_next[i] = 12'h000;
				max_next[i] = 12'h000;
				min_next[i] = 12'h000;
			end
			en_next = '0;
			due_next = '0;
			bnc_next = '0;
			dir_next = '0;
			equipment_identifier_next = TWS_RST_EQUIPMENT_IDENTIFIER;
		end
		if (BUS_I.rd) begin
			if (BUS_I.addr == TWS_A_CTRL) begin
				rd_next = {29'h0, ret_reg, odd_reg, hs_reg};
			end else if (BUS_I.addr == TWS_A_EQUIPMENT_IDENTIFIER) begin
				rd_next = {24'h0, equipment_identifier_reg};
			end else if (BUS_I.addr == TWS_A_DECODE) begin
				rd_next = {24'h0, EQUIPMENT_IDENTIFIER_VALID[equipment_identifier_reg] ? equipment_identifier_reg
					: TWS_DEF_DECODE};
			end else if (BUS_I.addr == TWS_A_STATUS) begin
				rd_next = {15'h0, !ser_ready, 6'h0, due_reg};
			end else if (in_slot) begin
				case (soff)
					TWS_O_WORD: rd_next = word_reg[sidx];
					TWS_O_IVAL: rd_next = {en_reg[sidx], 15'h0, ival_reg[sidx]};
					TWS_O_STEP: rd_next = {15'h0, bnc_reg[sidx], 4'h0, step_reg[sidx]};
					TWS_O_MAX: rd_next = {4'h0, max_reg[sidx], 16'h0};
					TWS_O_MIN: rd_next = {4'h0, min_reg[sidx], 16'h0};
					default: rd_next = 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// slot state kept across power loss only with retention on; RST_I always wipes it
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < N; i++) begin
				word_reg[i] <= 32'h0000_0000;
				ival_reg[i] <= 16'h0000;
				cnt_reg[i] <= 16'h0000;
				step_reg[i] <= 12'h000;
				max_reg[i] <= 12'h000;
				min_reg[i] <= 12'h000;
			end
			en_reg <= '0;
			due_reg <= '0;
			bnc_reg <= '0;
			dir_reg <= '0;
			ms_reg <= '0;
			{ret_reg, odd_reg, hs_reg} <= TWS_RST_CTRL;
			equipment_identifier_reg <= TWS_RST_EQUIPMENT_IDENTIFIER;
			rd_reg <= 32'h0000_0000;
		end else begin
			word_reg <= word_next;
			ival_reg <= ival_next;
			cnt_reg <= cnt_next;
			step_reg <= step_next;
			max_reg <= max_next;
			min_reg <= min_next;
			en_reg <= en_next;
			due_reg <= due_next;
			bnc_reg <= bnc_next;
			dir_reg <= dir_next;
			ms_reg <= ms_next;
			hs_reg <= hs_next;
			odd_reg <= odd_next;
			ret_reg <= ret_next;
			equipment_identifier_reg <= equipment_identifier_next;
			rd_reg <= rd_next;
		end
	end
	assign RDATA_O = rd_reg;

	tws_serial #(
		.GAP_CYC(GAP_CYC)
	) u_ser (
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.START_I(start),
		.WORD_I(tx_word),
		.HS_I(hs_reg),
		.READY_O(ser_ready),
		.HI_O(TX_HI_O),
		.LO_O(TX_LO_O)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_PRIO: assert property (@(posedge CLK_I) disable iff (RST_I)
		start |-> ((due_reg & ((10'h001 << pick) - 10'h001)) == '0))
		else $error("higher slot sent before lower due slot");
	AST_STEP_ZERO: assert property (@(posedge CLK_I) disable iff (RST_I)
		(start && step_reg[pick] == 12'h000 && !BUS_I.wr && !pwr_rise)
		|=> word_reg[$past(pick)][30:0] == $past(tx_word[30:0]))
		else $error("data changed with zero step");
	AST_WRAP: assert property (@(posedge CLK_I) disable iff (RST_I)
		(start && !bnc_reg[pick] && !step_reg[pick][11] && step_reg[pick] != 12'h000 && !BUS_I.wr && !pwr_rise
		&& word_reg[pick][27:16] == max_reg[pick]) |=> word_reg[$past(pick)][27:16] == $past(min_reg[pick]))
		else $error("wrap did not reload lower limit");
	AST_BOUNCE: assert property (@(posedge CLK_I) disable iff (RST_I)
		(start && bnc_reg[pick] && dir_reg[pick] && step_reg[pick] != 12'h000 && !BUS_I.wr && !pwr_rise
		&& word_reg[pick][27:16] == max_reg[pick]) |=> !dir_reg[$past(pick)])
		else $error("bounce did not reverse at upper limit");
	AST_CLEAR: assert property (@(posedge CLK_I) disable iff (RST_I)
		(pwr_rise && !ret_reg) |=> (en_reg == '0 && due_reg == '0))
		else $error("slots survived power-up without retention");
	AST_RETAIN: assert property (@(posedge CLK_I) disable iff (RST_I)
		(pwr_rise && ret_reg && !BUS_I.wr) |=> (en_reg == $past(en_reg)
		&& equipment_identifier_reg == $past(equipment_identifier_reg)))
		else $error("retained slots lost at power-up");
	AST_LIMIT_TRUNC: assert property (@(posedge CLK_I) disable iff (RST_I)
		(BUS_I.wr && in_slot && soff == TWS_O_MAX && !pwr_rise) |=> max_reg[$past(sidx)] == $past(BUS_I.wdata[27:16]))
		else $error("limit not truncated to bits 28..17");
	AST_PARITY: assert property (@(posedge CLK_I) disable iff (RST_I)
		start |-> (^tx_word) == odd_reg)
		else $error("parity does not match selection");
	AST_RETAIN_FLAG: assert property (@(posedge CLK_I) disable iff (RST_I)
		!(BUS_I.wr && BUS_I.addr == TWS_A_CTRL) |=> ret_reg == $past(ret_reg))
		else $error("retention flag changed without command");
	AST_POWER_HALT: assert property (@(posedge CLK_I) disable iff (RST_I)
		!pg2_reg |-> !start)
		else $error("word started while power down");
endmodule
`default_nettype wire

// [verification/tws_rx_model.sv]
// bipolar rz line receiver standing in for the equipment that receives the words
`timescale 1ns/1ns
`default_nettype none
module tws_rx_model #(
	parameter int HALF = 250,
	parameter int MIN_IDLE = 270
) (
	input wire logic clk_i,
	input wire logic tx_hi_i,
	input wire logic tx_lo_i,
	output logic [31:0] word_o,
	output logic stb_o,
	output int err_o
);
	// ----------------------------------------
	// decoder state
	// ----------------------------------------
	logic act;
	logic act_d;
	logic [31:0] sh;
	int cnt;
	int idle;
	int hrun;
	assign act = tx_hi_i | tx_lo_i;
	initial begin
		act_d = 1'b0;
		sh = 32'h0000_0000;
		cnt = 0;
		idle = MIN_IDLE;
		hrun = 0;
		word_o = 32'h0000_0000;
		stb_o = 1'b0;
		err_o = 0;
	end
	always @(posedge clk_i) begin
		act_d <= act;
		stb_o <= 1'b0;
		if (tx_hi_i && tx_lo_i)
			err_o <= err_o + 1;
		if (act && !act_d) begin
			if (cnt == 0 && idle < MIN_IDLE)
				err_o <= err_o + 1;
			sh <= {tx_hi_i, sh[31:1]};
			if (cnt == 31) begin
				word_o <= {tx_hi_i, sh[31:1]};
				stb_o <= 1'b1;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
			idle <= 0;
			hrun <= 1;
		end else if (act) begin
			hrun <= hrun + 1;
		end else begin
			// drive half of a fast cell
			if (act_d && hrun != HALF)
				err_o <= err_o + 1;
			if (idle < MIN_IDLE)
				idle <= idle + 1;
		end
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the transmit word scheduler
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import tws_pkg::*;
	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pwr_good_i = 1'b0;
	tws_bus_t bus = '0;
	logic [31:0] rdata;
	logic tx_hi;
	logic tx_lo;
	logic [31:0] rx_word;
	logic rx_stb;
	int rx_err;
	int n_fail = 0;
	int checks_done = 0;
	always #10 clk_i = ~clk_i;
	tws_top #(.CYC_PER_MS(50), .GAP_CYC(20)) u_dut (.CLK_I(clk_i), .RST_I(rst_i), .BUS_I(bus),
		.RDATA_O(rdata), .PWR_GOOD_I(pwr_good_i), .TX_HI_O(tx_hi), .TX_LO_O(tx_lo));
	tws_rx_model #(.HALF(250), .MIN_IDLE(270)) u_rx (.clk_i(clk_i), .tx_hi_i(tx_hi), .tx_lo_i(tx_lo),
		.word_o(rx_word), .stb_o(rx_stb), .err_o(rx_err));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
		bus <= '0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clk_i);
		bus <= '0;
		// data stands in the cycle after the strobe
		#1 d = rdata;
		@(posedge clk_i);
		// read data stands one cycle only
		#1 chk(rdata, 32'h0000_0000);
		@(posedge clk_i);
	endtask
	function automatic logic [11:0] sa(input int n, input logic [4:0] o);
		return TWS_A_SLOT_BASE + (12'(n) << TWS_SLOT_SHIFT) + {7'h00, o};
	endfunction
	function automatic logic [31:0] air(input logic [31:0] w, input logic [11:0] r, input logic odd);
		logic [31:0] v;
		v = (w & ~32'h0FFF_0000) | ({20'h0_0000, r} << TWS_RAMP_LSB);
		return {odd ? ~^v[30:0] : ^v[30:0], v[30:0]};
	endfunction
	task automatic power_cycle();
		pwr_good_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		pwr_good_i <= 1'b1;
		repeat (10) @(posedge clk_i);
	endtask
	task automatic get_word(input logic [31:0] exp);
		int n;
		n = 0;
		while (rx_stb !== 1'b1 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		// a word that never arrives counts as a mismatch
		if (n >= 20000)
			n_fail++;
		#1 chk(rx_word, exp);
		@(posedge clk_i);
	endtask
	task automatic wait_start();
		while (tx_hi || tx_lo)
			@(posedge clk_i);
		while (!(tx_hi || tx_lo))
			@(posedge clk_i);
	endtask
	// ----------------------------------------
	// register rows
	// ----------------------------------------
	typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e;} tws_row_t;
	tws_row_t rows [12];
	initial begin
		rows[0] = '{TWS_A_CTRL, 1'b0, 32'h0, 32'h0000_0000};
		rows[1] = '{TWS_A_EQUIPMENT_IDENTIFIER, 1'b0, 32'h0, 32'h0000_0000};
		rows[2] = '{12'h800, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000};
		rows[3] = '{sa(9, 5'h14), 1'b0, 32'h0, 32'h0000_0000};
		rows[4] = '{sa(9, TWS_O_IVAL), 1'b1, 32'h0000_0001, 32'h0000_0004};
		rows[5] = '{sa(9, TWS_O_IVAL), 1'b1, 32'h0000_FFFF, 32'h0000_EA5E};
		rows[6] = '{sa(9, TWS_O_MAX), 1'b1, 32'hFFFF_FFFF, 32'h0FFF_0000};
		rows[7] = '{sa(9, TWS_O_MIN), 1'b1, 32'h1234_5678, 32'h0234_0000};
		rows[8] = '{sa(9, TWS_O_STEP), 1'b1, 32'h0001_0FFF, 32'h0001_0FFF};
		rows[9] = '{TWS_A_EQUIPMENT_IDENTIFIER, 1'b1, 32'h0000_0005, 32'h0000_0005};
		rows[10] = '{TWS_A_DECODE, 1'b0, 32'h0, 32'h0000_0005};
		rows[11] = '{sa(9, TWS_O_WORD), 1'b1, 32'h8765_4321, 32'h8765_4321};
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		pwr_good_i <= 1'b1;
		#1 chk({rdata[31:2], tx_hi, tx_lo}, 32'h0000_0000);
		repeat (10) @(posedge clk_i);
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a, d);
			chk(d, rows[i].e);
		end
		// identifier zero is outside the valid mask
		wr(TWS_A_EQUIPMENT_IDENTIFIER, 32'h0000_0000);
		rd(TWS_A_DECODE, d);
		chk(d, {24'h00_0000, TWS_DEF_DECODE});
		power_cycle();
		rd(sa(9, TWS_O_WORD), d);
		chk(d, 32'h0000_0000);
		rd(sa(9, TWS_O_MAX), d);
		chk(d, 32'h0000_0000);
		wr(TWS_A_CTRL, 32'h0000_0004);
		wr(TWS_A_EQUIPMENT_IDENTIFIER, 32'h0000_0005);
		wr(sa(9, TWS_O_WORD), 32'h1357_9BDF);
		power_cycle();
		rd(TWS_A_CTRL, d);
		chk(d, 32'h0000_0004);
		rd(TWS_A_EQUIPMENT_IDENTIFIER, d);
		chk(d, 32'h0000_0005);
		rd(sa(9, TWS_O_WORD), d);
		chk(d, 32'h1357_9BDF);
		// fast line, odd parity, wrap ramp on slot 0
		wr(TWS_A_CTRL, 32'h0000_0007);
		wr(sa(0, TWS_O_WORD), 32'h2010_0203);
		wr(sa(0, TWS_O_STEP), 32'h0000_0001);
		wr(sa(0, TWS_O_MAX), 32'h0011_0000);
		wr(sa(0, TWS_O_MIN), 32'h000F_0000);
		wr(sa(1, TWS_O_WORD), 32'h4000_0105);
		// slot 0 enabled first so a tick between writes cannot favour slot 1
		wr(sa(0, TWS_O_IVAL), 32'h8000_0004);
		wr(sa(1, TWS_O_IVAL), 32'h8000_0004);
		get_word(air(32'h2010_0203, 12'h010, 1'b1));
		get_word(air(32'h2010_0203, 12'h011, 1'b1));
		wait_start();
		// parity change and bounce setup mid-word show on the next word
		wr(TWS_A_CTRL, 32'h0000_0005);
		wr(sa(0, TWS_O_STEP), 32'h0001_0001);
		wr(sa(0, TWS_O_WORD), 32'h2011_0203);
		get_word(air(32'h2010_0203, 12'h00F, 1'b1));
		// bounce word sent at the upper limit, then slot 0 stopped
		wait_start();
		wr(sa(0, TWS_O_IVAL), 32'h0000_0000);
		get_word(air(32'h2011_0203, 12'h011, 1'b0));
		rd(sa(0, TWS_O_WORD), d);
		chk(d, 32'h2011_0203);
		get_word(air(32'h4000_0105, 12'h000, 1'b0));
		chk(32'(rx_err), 32'h0000_0000);
		results();
	end
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (90000) @(posedge clk_i);
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
